// ===== ebarb_pkg.sv
package ebarb_pkg;

    localparam logic [1:0] EBARB_MODE_NORMAL = 2'h0;
    localparam logic [1:0] EBARB_MODE_SLAVE = 2'h1;
    localparam logic [1:0] EBARB_MODE_COMPANION = 2'h2;

    localparam logic [1:0] EBARB_SHOW_OFF = 2'h0;
    localparam logic [1:0] EBARB_SHOW_NOGRANT = 2'h1;
    localparam int EBARB_SHOW_FULL_BIT = 1;

    localparam int EBARB_ID_W = 3;
    localparam int EBARB_NMASTERS = 3;
    localparam int EBARB_SYNC_STAGES = 2;

    localparam logic [1:0] EBARB_SIZE_LONG = 2'h0;
    localparam logic [1:0] EBARB_SIZE_BYTE = 2'h1;
    localparam logic [1:0] EBARB_SIZE_WORD = 2'h2;
    localparam logic [1:0] EBARB_SIZE_THREE = 2'h3;
    localparam logic [1:0] EBARB_PORT_8 = 2'h2;
    localparam logic [1:0] EBARB_PORT_16 = 2'h1;
    localparam logic [1:0] EBARB_PORT_32 = 2'h0;

    typedef struct packed {
        logic [1:0] mode;
        logic sync_arb_timing;
        logic [1:0] show_cycle_sel;
        logic [EBARB_ID_W-1:0] companion_priority_id;
        logic [EBARB_ID_W-1:0] bus_clear_in_level;
    } ebarb_cfg_t;

    typedef struct packed {
        logic address_strobe_n;
        logic locked_rmw_n;
        logic bus_error_n;
        logic [1:0] port_width_ack_n;
        logic [1:0] transfer_size;
        logic cycle_active;
        logic operand_last_hint;
        logic internal_access;
        logic external_access;
    } ebarb_bus_t;

    typedef struct packed {
        logic bus_request_n;
        logic grant_acknowledge_n;
        logic bus_grant_n;
        logic bus_clear_in_n;
    } ebarb_pins_t;

endpackage : ebarb_pkg

// ===== ebarb_sync.sv
`timescale 1ns/10ps
module ebarb_sync
    import ebarb_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // two flops; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q_reg <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule : ebarb_sync

// ===== ebarb_arbiter.sv
`timescale 1ns/10ps
// Contract
// - on external request, release bus after finishing any started cycle
// - request withdrawn before acknowledge: keep mastership, no release
// - multi-cycle operand keeps the bus until all cycles complete
// - synchronous timing allows grant one clock after request
// - withhold grant until final cycle per transfer size and port acks
// - locked read-modify-write blocks grant and ignores requests; bus error aborts
// - show 1x waits internal access end; 00 grants; 01 never grants
// - acknowledging master owns bus until negation; device then resumes
// - first own cycle after acknowledge negates: sync one clock, show 1x adds one (here show 1x delays only the return to idle, not ownership)
// - request still asserted with acknowledge means prepare another grant
// - asynchronous inputs synchronized within two clocks before use
// - float outputs on edge after strobe and lock both negate
// - states change on edge after input valid; grant follows state
// - idle state zero with grant and float negated while master
// - slave mode: request, wait grant with acknowledge negated, then acknowledge
// - slave mode drives acknowledge only while owning, else three-stated
// - companion mode: grant held idle; take bus via busy; release reverses
// - companion priority decides ties and preemption while busy
// - bus clear in clears internal masters with ID below level
// - slave mode forces show field 00; sync acknowledge after one clock
// - slave mode requests bus only for external accesses
module ebarb_arbiter
    import ebarb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ebarb_cfg_t cfg,
    input wire ebarb_bus_t bus,
    input wire ebarb_pins_t pins_in,
    input wire logic [EBARB_NMASTERS-1:0] master_req,
    input wire logic [EBARB_NMASTERS*EBARB_ID_W-1:0] master_id,
    output logic bus_request_n_o,
    output logic bus_request_n_oe,
    output logic bus_grant_n_o,
    output logic grant_acknowledge_n_o,
    output logic grant_acknowledge_n_oe,
    output logic bus_busy_n_o,
    output logic bus_busy_n_oe,
    output logic bus_float,
    output logic device_owns_bus,
    output logic [EBARB_NMASTERS-1:0] master_clear
);
    typedef enum logic [2:0] {
        EBARB_ST_IDLE, EBARB_ST_PEND, EBARB_ST_GRANT, EBARB_ST_EXT, EBARB_ST_REGRANT, EBARB_ST_RETURN
    } ebarb_state_t;
    typedef enum logic [1:0] {
        EBARB_SL_IDLE, EBARB_SL_REQ, EBARB_SL_OWN
    } ebarb_slave_t;
    typedef enum logic [1:0] {
        EBARB_CP_IDLE, EBARB_CP_OWN, EBARB_CP_GIVE
    } ebarb_comp_t;

    ebarb_state_t state_reg, state_next;
    ebarb_slave_t sl_reg, sl_next;
    ebarb_comp_t cp_reg, cp_next;

    logic [3:0] sync_d, sync_q;
    logic req_a, ack_a, grant_a, clr_a;
    logic grant_term, float_term;
    logic operand_done, safe_point, show_ok, lock_hold;
    logic need_ext, any_master, slave_mode, comp_mode, normal_mode;
    logic [1:0] show_eff;
    logic return_wait_reg, return_wait_next;
    logic float_reg, float_next;
    logic grant_n_reg, br_n_reg, br_oe_reg, ga_n_reg, ga_oe_reg, bb_n_reg, bb_oe_reg;
    logic owns_reg;
    logic [EBARB_NMASTERS-1:0] clear_reg, clear_next;
    logic comp_wins;

    function automatic logic last_cycle(input logic [1:0] size, input logic [1:0] ack_n);
        logic [1:0] ack;
        ack = ~ack_n;
        if (ack == EBARB_PORT_32)
            return 1'b0;
        if (ack == ~EBARB_PORT_32)
            return 1'b1;
        if (ack == ~EBARB_PORT_16)
            return (size == EBARB_SIZE_BYTE) || (size == EBARB_SIZE_WORD);
        return size == EBARB_SIZE_BYTE;
    endfunction : last_cycle

    function automatic logic id_below(input logic [EBARB_ID_W-1:0] id, input logic [EBARB_ID_W-1:0] lvl);
        return id < lvl;
    endfunction : id_below

    // synchronise the pin inputs
    assign sync_d = {pins_in.bus_request_n, pins_in.grant_acknowledge_n, pins_in.bus_grant_n,
                     pins_in.bus_clear_in_n};
    ebarb_sync #(.WIDTH(4), .RESET_VAL(4'hF)) u_sync (
        .clk(clk),
        .rst(rst),
        .d(sync_d),
        .q(sync_q)
    );

    // synchronous timing bypasses the synchroniser delay for request, acknowledge and grant; bus clear in always uses it
    assign req_a = cfg.sync_arb_timing ? ~pins_in.bus_request_n : ~sync_q[3];
    assign ack_a = cfg.sync_arb_timing ? ~pins_in.grant_acknowledge_n : ~sync_q[2];
    assign grant_a = cfg.sync_arb_timing ? ~pins_in.bus_grant_n : ~sync_q[1];
    assign clr_a = ~sync_q[0];

    assign normal_mode = cfg.mode == EBARB_MODE_NORMAL;
    assign slave_mode = cfg.mode == EBARB_MODE_SLAVE;
    assign comp_mode = cfg.mode == EBARB_MODE_COMPANION;
    // slave mode forces show cycles off
    assign show_eff = slave_mode ? EBARB_SHOW_OFF : cfg.show_cycle_sel;

    // operand boundary: idle or final cycle of operand
    assign operand_done = ~bus.cycle_active
        || (bus.operand_last_hint && last_cycle(bus.transfer_size, bus.port_width_ack_n));
    // locked sequence holds grant unless aborted by bus error
    assign lock_hold = ~bus.locked_rmw_n && bus.bus_error_n;
    // show cycle gating of grant
    assign show_ok = (show_eff == EBARB_SHOW_NOGRANT) ? 1'b0 :
                     show_eff[EBARB_SHOW_FULL_BIT] ? ~bus.internal_access : 1'b1;
    assign safe_point = operand_done && ~lock_hold && show_ok;

    // grant and float terms per state
    assign grant_term = (state_reg == EBARB_ST_GRANT) || (state_reg == EBARB_ST_REGRANT);
    assign float_term = (state_reg != EBARB_ST_IDLE) && (state_reg != EBARB_ST_PEND)
                        && (state_reg != EBARB_ST_RETURN);

    always_comb begin
        state_next = state_reg;
        return_wait_next = 1'b0;
        unique case (state_reg)
            EBARB_ST_IDLE: begin
                // requests ignored during locked sequence
                if (normal_mode && (req_a || ack_a) && ~lock_hold)
                    state_next = (req_a && safe_point) ? EBARB_ST_GRANT : EBARB_ST_PEND;
            end
            EBARB_ST_PEND: begin
                if (ack_a)
                    state_next = EBARB_ST_EXT;
                else if (~req_a)
                    state_next = EBARB_ST_IDLE;
                else if (safe_point)
                    state_next = EBARB_ST_GRANT;
            end
            EBARB_ST_GRANT: begin
                if (ack_a)
                    state_next = EBARB_ST_EXT;
                else if (~req_a)
                    state_next = EBARB_ST_IDLE;
            end
            EBARB_ST_EXT: begin
                if (~ack_a)
                    state_next = req_a ? EBARB_ST_REGRANT : EBARB_ST_RETURN;
                else if (req_a)
                    state_next = EBARB_ST_REGRANT;
            end
            EBARB_ST_REGRANT: begin
                if (ack_a && ~req_a)
                    state_next = EBARB_ST_EXT;
                else if (~ack_a && ~req_a)
                    state_next = EBARB_ST_RETURN;
            end
            EBARB_ST_RETURN: begin
                // show 1x adds a clock before returning to idle; ownership is not delayed
                if (show_eff[EBARB_SHOW_FULL_BIT] && ~return_wait_reg)
                    return_wait_next = 1'b1;
                else
                    state_next = EBARB_ST_IDLE;
            end
            default: state_next = EBARB_ST_IDLE;
        endcase
    end

    // float after strobe and lock both negate
    assign float_next = float_term && (float_reg || (bus.address_strobe_n && bus.locked_rmw_n));

    // slave mode: request only for external access
    assign need_ext = bus.external_access && |master_req;
    always_comb begin
        sl_next = sl_reg;
        unique case (sl_reg)
            EBARB_SL_IDLE: if (slave_mode && need_ext) sl_next = EBARB_SL_REQ;
            EBARB_SL_REQ: begin
                if (grant_a && ~ack_a)
                    sl_next = EBARB_SL_OWN;
                else if (~need_ext)
                    sl_next = EBARB_SL_IDLE;
            end
            EBARB_SL_OWN: if (~need_ext && operand_done) sl_next = EBARB_SL_IDLE;
            default: sl_next = EBARB_SL_IDLE;
        endcase
    end

    // companion priority decides ties and preemption
    assign any_master = |master_req;
    assign comp_wins = cfg.companion_priority_id > cfg.bus_clear_in_level;
    always_comb begin
        cp_next = cp_reg;
        unique case (cp_reg)
            EBARB_CP_IDLE: begin
                if (comp_mode && any_master && (~req_a || ~comp_wins))
                    cp_next = EBARB_CP_OWN;
            end
            EBARB_CP_OWN: begin
                if (~any_master || (req_a && comp_wins && operand_done && ~lock_hold))
                    cp_next = EBARB_CP_GIVE;
            end
            EBARB_CP_GIVE: cp_next = EBARB_CP_IDLE;
            default: cp_next = EBARB_CP_IDLE;
        endcase
    end

    // bus clear in clears lower-id masters
    always_comb begin
        for (int i = 0; i < EBARB_NMASTERS; i++) begin
            clear_next[i] = clr_a && master_req[i]
                && id_below(master_id[i*EBARB_ID_W +: EBARB_ID_W], cfg.bus_clear_in_level);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= EBARB_ST_IDLE;
            sl_reg <= EBARB_SL_IDLE;
            cp_reg <= EBARB_CP_IDLE;
            return_wait_reg <= 1'b0;
            float_reg <= 1'b0;
            clear_reg <= '0;
        end else begin
            state_reg <= state_next;
            sl_reg <= sl_next;
            cp_reg <= cp_next;
            return_wait_reg <= return_wait_next;
            float_reg <= float_next;
            clear_reg <= clear_next;
        end
    end

    // registered pin drivers
    always_ff @(posedge clk) begin
        if (rst) begin
            grant_n_reg <= 1'b1;
            br_n_reg <= 1'b1;
            br_oe_reg <= 1'b0;
            ga_n_reg <= 1'b1;
            ga_oe_reg <= 1'b0;
            bb_n_reg <= 1'b1;
            bb_oe_reg <= 1'b0;
            owns_reg <= 1'b1;
        end else begin
            // companion idle holds grant; normal follows state
            grant_n_reg <= comp_mode ? (cp_reg == EBARB_CP_OWN) : ~(normal_mode && grant_term);
            br_n_reg <= ~(sl_reg == EBARB_SL_REQ);
            br_oe_reg <= slave_mode;
            ga_n_reg <= ~(sl_reg == EBARB_SL_OWN);
            ga_oe_reg <= sl_reg == EBARB_SL_OWN;
            bb_n_reg <= ~(cp_reg == EBARB_CP_OWN);
            bb_oe_reg <= cp_reg == EBARB_CP_OWN;
            owns_reg <= normal_mode ? ~float_term : (slave_mode ? sl_reg == EBARB_SL_OWN : cp_reg == EBARB_CP_OWN);
        end
    end

    assign bus_grant_n_o = grant_n_reg;
    assign bus_request_n_o = br_n_reg;
    assign bus_request_n_oe = br_oe_reg;
    assign grant_acknowledge_n_o = ga_n_reg;
    assign grant_acknowledge_n_oe = ga_oe_reg;
    assign bus_busy_n_o = bb_n_reg;
    assign bus_busy_n_oe = bb_oe_reg;
    assign bus_float = float_reg;
    assign device_owns_bus = owns_reg;
    assign master_clear = clear_reg;

endmodule : ebarb_arbiter

// ===== ebarb_properties.sv
`timescale 1ns/10ps
module ebarb_chk
    import ebarb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ebarb_cfg_t cfg,
    input wire ebarb_bus_t bus,
    input wire ebarb_pins_t pins_in,
    input wire logic [EBARB_NMASTERS-1:0] master_req,
    input wire logic [EBARB_NMASTERS*EBARB_ID_W-1:0] master_id,
    input wire logic bus_request_n_o,
    input wire logic bus_grant_n_o,
    input wire logic bus_busy_n_o,
    input wire logic bus_busy_n_oe,
    input wire logic bus_float,
    input wire logic device_owns_bus,
    input wire logic [EBARB_NMASTERS-1:0] master_clear
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire nrm = cfg.mode == EBARB_MODE_NORMAL;
    wire idl = nrm && cfg.sync_arb_timing && cfg.show_cycle_sel == EBARB_SHOW_OFF && !pins_in.bus_request_n
        && pins_in.grant_acknowledge_n && bus.locked_rmw_n && !bus.cycle_active;
    reset_idle_a: assert property ($fell(rst) |-> bus_grant_n_o && device_owns_bus && !bus_float)
        else $error("arbiter not idle after reset");
    sync_grant_a: assert property (idl [*4] |-> ##[0:2] !bus_grant_n_o)
        else $error("grant late in synchronous idle case");
    lock_blocks_a: assert property (nrm && $fell(bus_grant_n_o) |-> $past(bus.locked_rmw_n) || !$past(bus.bus_error_n))
        else $error("grant during locked sequence");
    show_never_a: assert property (nrm && cfg.show_cycle_sel == EBARB_SHOW_NOGRANT |-> bus_grant_n_o)
        else $error("grant with show field 01");
    show_wait_a: assert property (nrm && cfg.show_cycle_sel[EBARB_SHOW_FULL_BIT] && $fell(bus_grant_n_o)
        |-> !$past(bus.internal_access))
        else $error("grant during internal access");
    float_after_a: assert property ($rose(bus_float) |-> $past(bus.address_strobe_n && bus.locked_rmw_n))
        else $error("float before strobe and lock negate");
    keep_master_a: assert property ((nrm && pins_in.grant_acknowledge_n && pins_in.bus_request_n) [*8]
        |-> device_owns_bus)
        else $error("mastership lost without acknowledge");
    clear_level_a: assert property ((!pins_in.bus_clear_in_n && master_req[0]
        && master_id[2:0] < cfg.bus_clear_in_level) [*4]
        |-> master_clear[0])
        else $error("bus clear not applied");
    slave_req_a: assert property (cfg.mode == EBARB_MODE_SLAVE && $fell(bus_request_n_o)
        |-> $past(bus.external_access))
        else $error("request without external access");
    comp_busy_a: assert property (cfg.mode == EBARB_MODE_COMPANION && bus_busy_n_oe && !bus_busy_n_o
        |-> bus_grant_n_o)
        else $error("grant held while busy");
    cover property (nrm && $fell(bus_grant_n_o));
    cover property ($rose(bus_float));
    cover property (|master_clear);
endmodule : ebarb_chk

bind ebarb_arbiter ebarb_chk u_chk (.clk, .rst, .cfg, .bus, .pins_in, .master_req, .master_id, .bus_request_n_o,
    .bus_grant_n_o, .bus_busy_n_o, .bus_busy_n_oe, .bus_float, .device_owns_bus, .master_clear);

// ===== ebarb_xm.sv
`timescale 1ns/10ps
module ebarb_xm (
    input wire logic clk,
    input wire logic want,
    input wire logic ack_en,
    input wire logic keep_req,
    input wire logic bus_grant_n,
    output logic bus_request_n,
    output logic grant_acknowledge_n
);
    initial begin
        bus_request_n = 1'h1;
        grant_acknowledge_n = 1'h1;
    end
    // external master: takes the bus only on grant while ack_en is set
    always @(negedge clk) begin
        if (!grant_acknowledge_n) begin
            grant_acknowledge_n <= !want;
            bus_request_n <= !keep_req;
        end else if (want && ack_en && !bus_grant_n) begin
            grant_acknowledge_n <= 1'h0;
            bus_request_n <= !keep_req;
        end else begin
            bus_request_n <= !want;
        end
    end
endmodule : ebarb_xm

// ===== testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench
    import ebarb_pkg::*;
;
    logic clk, rst, bclr_n, gnt_n, want, ack_en, keep_req, xreq_n, xack_n;
    logic rq_o, rq_oe, bg_o, ga_o, ga_oe, bb_o, bb_oe, flt, own;
    logic [2:0] clr, mreq;
    logic [8:0] mid;
    int n_mismatch = 0;
    int checks = 0;
    ebarb_cfg_t cfg;
    ebarb_bus_t bus;
    ebarb_pins_t pins;
    wire rq_pin = xreq_n & (rq_oe ? rq_o : 1'h1);
    wire ga_pin = xack_n & (ga_oe ? ga_o : 1'h1);
    wire bb_pin = bb_oe ? bb_o : 1'h1;
    assign pins = '{rq_pin, ga_pin, gnt_n, bclr_n};
    ebarb_arbiter dut (.clk(clk), .rst(rst), .cfg(cfg), .bus(bus), .pins_in(pins), .master_req(mreq),
        .master_id(mid), .bus_request_n_o(rq_o), .bus_request_n_oe(rq_oe), .bus_grant_n_o(bg_o),
        .grant_acknowledge_n_o(ga_o), .grant_acknowledge_n_oe(ga_oe), .bus_busy_n_o(bb_o),
        .bus_busy_n_oe(bb_oe), .bus_float(flt), .device_owns_bus(own), .master_clear(clr));
    ebarb_xm xm (.clk(clk), .want(want), .ack_en(ack_en), .keep_req(keep_req), .bus_grant_n(bg_o),
        .bus_request_n(xreq_n), .grant_acknowledge_n(xack_n));
    always #50 clk = ~clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic rst_cfg(input logic [1:0] md, input logic [1:0] sh, input logic sy);
        rst = 1'h1;
        cfg.mode = md;
        cfg.show_cycle_sel = sh;
        cfg.sync_arb_timing = sy;
        cyc(4);
        rst = 1'h0;
    endtask : rst_cfg
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        clk = 1'h0;
        rst = 1'h1;
        cfg = '{EBARB_MODE_NORMAL, 1'h1, EBARB_SHOW_OFF, 3'h1, 3'h4};
        bus = '{1'h1, 1'h1, 1'h1, 2'h3, EBARB_SIZE_LONG, 1'h0, 1'h0, 1'h0, 1'h0};
        mreq = 3'h0;
        mid = {3'h6, 3'h5, 3'h3};
        {bclr_n, gnt_n, want, ack_en, keep_req} = 5'h18;
        rst_cfg(EBARB_MODE_NORMAL, EBARB_SHOW_OFF, 1'h1);
        cyc(1);
        `CHK("grant_rst", 1'h1, bg_o);
        `CHK("owns_rst", 1'h1, own);
        want = 1'h1;
        cyc(4);
        `CHK("grant", 1'h0, bg_o);
        `CHK("float", 1'h1, flt);
        ack_en = 1'h1;
        cyc(4);
        `CHK("owns_ext", 1'h0, own);
        want = 1'h0;
        cyc(6);
        `CHK("owns_back", 1'h1, own);
        {want, keep_req} = 2'h3;
        cyc(4);
        ack_en = 1'h0;
        cyc(6);
        `CHK("regrant", 1'h0, bg_o);
        {want, keep_req} = 2'h0;
        cyc(8);
        bus.locked_rmw_n = 1'h0;
        want = 1'h1;
        cyc(6);
        `CHK("grant_lock", 1'h1, bg_o);
        want = 1'h0;
        cyc(2);
        bus.locked_rmw_n = 1'h1;
        cyc(8);
        `CHK("owns_wd", 1'h1, own);
        {bus.locked_rmw_n, bus.bus_error_n, want} = 3'h1;
        cyc(6);
        `CHK("grant_bus_error_n", 1'h0, bg_o);
        {bus.locked_rmw_n, bus.bus_error_n, want} = 3'h6;
        cyc(8);
        {bus.cycle_active, bus.port_width_ack_n, want} = 4'h9;
        cyc(6);
        `CHK("grant_mid", 1'h1, bg_o);
        bus.operand_last_hint = 1'h1;
        cyc(4);
        `CHK("grant_last", 1'h0, bg_o);
        {bus.cycle_active, bus.port_width_ack_n, bus.operand_last_hint, want} = 5'h0C;
        cyc(8);
        for (int s = 0; s < 3; s++) begin
            rst_cfg(EBARB_MODE_NORMAL, 2'(s), 1'h1);
            {bus.internal_access, want} = 2'h3;
            cyc(6);
            `CHK("grant_int", (s == 0) ? 1'h0 : 1'h1, bg_o);
            bus.internal_access = 1'h0;
            cyc(4);
            `CHK("grant_end", (s == 1) ? 1'h1 : 1'h0, bg_o);
            want = 1'h0;
            cyc(8);
        end
        rst_cfg(EBARB_MODE_NORMAL, EBARB_SHOW_OFF, 1'h0);
        {bclr_n, mreq} = 4'h7;
        cyc(5);
        `CHK("clear", 3'h1, clr);
        bclr_n = 1'h1;
        rst_cfg(EBARB_MODE_SLAVE, EBARB_SHOW_OFF, 1'h1);
        {mreq, bus.internal_access} = 4'h3;
        cyc(4);
        `CHK("req_int", 1'h1, rq_pin);
        {bus.internal_access, bus.external_access} = 2'h1;
        cyc(4);
        `CHK("req_ext", 1'h0, rq_pin);
        `CHK("ack_oe_idle", 1'h0, ga_oe);
        gnt_n = 1'h0;
        cyc(4);
        `CHK("ack_slave", 1'h0, ga_pin);
        {mreq, bus.external_access, gnt_n} = 5'h1;
        cyc(8);
        `CHK("ack_oe_rel", 1'h0, ga_oe);
        rst_cfg(EBARB_MODE_COMPANION, EBARB_SHOW_OFF, 1'h1);
        cyc(4);
        `CHK("grant_comp", 1'h0, bg_o);
        {mreq, bus.external_access} = 4'h3;
        cyc(6);
        `CHK("grant_busy", 1'h1, bg_o);
        `CHK("busy", 1'h0, bb_pin);
        {mreq, bus.external_access} = 4'h0;
        cyc(6);
        `CHK("grant_rel", 1'h0, bg_o);
        `CHK("busy_oe", 1'h0, bb_oe);
        end_of_test();
    end
endmodule : testbench
